// ---- verification/sarp_monitor.sv ----
// pin assertions on the link between host and converter ends
module sarp_monitor
  import sarp_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic cs_n,
  input wire logic rc,
  input wire logic busy_n,
  input wire sarp_pkg::sarp_word_t result_bus_o,
  input wire logic result_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);
  // oe lags the pins by the synchronisers, hence four cycles
  oe_idle_only_a: assert property (result_bus_oe |-> busy_n)
    else $error("bus driven during conversion");
  oe_cs_off_a: assert property (cs_n [*4] |-> !result_bus_oe)
    else $error("bus driven while deselected");
  oe_rc_off_a: assert property (!rc [*4] |-> !result_bus_oe)
    else $error("bus driven in convert mode");
  start_pulse_a: assert property ($fell(busy_n) |->
    $past(!cs_n && !rc, 3) && $past(!cs_n && !rc, 4))
    else $error("conversion without full low pulse");
  busy_min_a: assert property ($fell(busy_n) |-> !busy_n [*8])
    else $error("busy too short");
  busy_max_a: assert property ($fell(busy_n) |-> ##[8:40] busy_n)
    else $error("busy never ended");
  // result and busy are updated by the same load edge
  load_then_busy_a: assert property ($changed(result_bus_o) |-> $rose(busy_n))
    else $error("result changed outside load");
  read_after_conv_a: assert property ($rose(busy_n) && rc && !cs_n |->
    ##[0:4] result_bus_oe)
    else $error("bus not driven after conversion");
  spacing_a: assert property ($rose(busy_n) |-> busy_n [*8])
    else $error("conversions too close");
  cover property ($fell(busy_n));
  cover property ($rose(result_bus_oe));
  cover property ($rose(busy_n) && rc);
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench joining the host and converter ends
module tb_top
  import sarp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic START = 1'b0;
  logic SAMPLE_VALID = 1'b0;
  sarp_word_t SAMPLE_CODE = 12'h000;
  logic SAMPLE_READY, HOLD, DONE, IDLE;
  sarp_word_t RESULT;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  sarp_if link ();
  // short counts keep the run brief
  sarp_dev #(.PULSE_CYC(2), .CONV_CYC(8)) sarp_dev_inst (.MCLK(MCLK), .RESETN(RESETN),
    .LINK(link.dev), .SAMPLE_CODE(SAMPLE_CODE), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_READY(SAMPLE_READY), .HOLD(HOLD));
  sarp_host #(.PULSE_CYC(2), .SETUP_CYC(1), .SPACING_CYC(12)) sarp_host_inst (.MCLK(MCLK),
    .RESETN(RESETN), .LINK(link.host), .START(START), .DONE(DONE), .RESULT(RESULT),
    .IDLE(IDLE));
  sarp_monitor sarp_monitor_inst (.MCLK(MCLK), .RESETN(RESETN), .cs_n(link.cs_n),
    .rc(link.rc), .busy_n(link.busy_n), .result_bus_o(link.result_bus_o),
    .result_bus_oe(link.result_bus_oe));
  always #10 MCLK = ~MCLK;
  task automatic finish_test();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input sarp_word_t got, input sarp_word_t exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic push(input sarp_word_t code);
    int n;
    n = 0;
    @(posedge MCLK);
    SAMPLE_CODE <= code;
    SAMPLE_VALID <= 1'b1;
    // release at the edge where ready is seen high, so the word is taken once
    do begin
      @(posedge MCLK);
      n++;
    end while (SAMPLE_READY !== 1'b1 && n < 50);
    SAMPLE_VALID <= 1'b0;
  endtask
  task automatic conv(input sarp_word_t exp);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    do begin
      @(negedge MCLK);
      n++;
    end while (IDLE !== 1'b1 && n < 200);
    @(posedge MCLK);
    START <= 1'b1;
    @(posedge MCLK);
    START <= 1'b0;
    do begin
      @(negedge MCLK);
      n++;
    end while (link.busy_n !== 1'b0 && n < 300);
    chk({11'h000, HOLD}, 12'h001);
    do begin
      @(negedge MCLK);
      n++;
      if (link.result_bus_oe === 1'b1) begin
        hit = 1'b1;
      end
    end while (DONE !== 1'b1 && n < 400);
    chk(RESULT, exp);
    chk(link.result_bus_o, exp);
    chk({11'h000, hit}, 12'h001);
    chk({11'h000, HOLD}, 12'h000);
    repeat (5) @(negedge MCLK);
    chk(link.result_bus_o, exp);
  endtask
  initial begin
    repeat (2) @(posedge MCLK);
    RESETN <= 1'b1;
    push(12'h7FF);
    push(12'h000);
    @(negedge MCLK);
    chk({11'h000, SAMPLE_READY}, 12'h000);
    conv(12'h7FF);
    conv(12'h000);
    push(12'hFFF);
    conv(12'hFFF);
    push(12'h800);
    conv(12'h800);
    finish_test();
  end
endmodule

// ---- verilog/sarp_dev.sv ----
// converter end: convert control, busy flag, result register, bus enable
module sarp_dev
  import sarp_pkg::*;
#(
  parameter int PULSE_CYC = SARP_PULSE_CYC,
  parameter int CONV_CYC = SARP_CONV_CYC
) (
  input wire logic MCLK,
  input wire logic RESETN,
  sarp_if.dev LINK,
  input wire sarp_pkg::sarp_word_t SAMPLE_CODE,
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  output logic HOLD
);
  import sarp_pkg::*;

  typedef enum logic [1:0] {SARP_TRACK, SARP_CONV, SARP_LOAD} sarp_state_t;
  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic rc_m;
    logic rc_s;
    sarp_state_t st;
    logic [SARP_CNT_W-1:0] lowcnt;
    logic [SARP_CNT_W-1:0] convcnt;
    sarp_word_t result;
    logic [1:0] fill;
    sarp_word_t buf0;
    sarp_word_t buf1;
    logic busy_n;
    logic oe;
    logic ready;
    logic hold;
  } sarp_dev_st_t;

  sarp_dev_st_t s_r, s_nxt;

  logic req_low;
  logic done;

  always_comb begin
    s_nxt = s_r;
    // pin inputs pass two flops; only the second is read
    s_nxt.cs_m = LINK.cs_n;
    s_nxt.cs_s = s_r.cs_m;
    s_nxt.rc_m = LINK.rc;
    s_nxt.rc_s = s_r.rc_m;
    req_low = !s_r.cs_s && !s_r.rc_s;
    done = 1'b0;
    // two-entry sample buffer so a stalled converter drops no word
    if (SAMPLE_VALID && s_r.ready) begin
      if (s_r.fill == 2'd0) begin
        s_nxt.buf0 = SAMPLE_CODE;
      end else begin
        s_nxt.buf1 = SAMPLE_CODE;
      end
    end
    unique case (s_r.st)
      SARP_TRACK: begin
        // low must persist the full pulse width; a glitch restarts the count
        if (req_low) begin
          if (s_r.lowcnt >= SARP_CNT_W'(PULSE_CYC - 1)) begin
            s_nxt.st = SARP_CONV;
            s_nxt.convcnt = '0;
            s_nxt.busy_n = 1'b0;
            s_nxt.hold = 1'b1;
            s_nxt.lowcnt = '0;
          end else begin
            s_nxt.lowcnt = s_r.lowcnt + 1'b1;
          end
        end else begin
          s_nxt.lowcnt = '0;
        end
      end
      SARP_CONV: begin
        // requests during busy are simply not looked at
        s_nxt.lowcnt = '0;
        if (s_r.convcnt >= SARP_CNT_W'(CONV_CYC - 1)) begin
          if (s_r.fill != 2'd0) begin
            s_nxt.st = SARP_LOAD;
          end
        end else begin
          s_nxt.convcnt = s_r.convcnt + 1'b1;
        end
      end
      SARP_LOAD: begin
        done = 1'b1;
        s_nxt.result = s_r.buf0;
        s_nxt.busy_n = 1'b1;
        s_nxt.hold = 1'b0;
        s_nxt.st = SARP_TRACK;
      end
      default: begin
        s_nxt.st = SARP_TRACK;
      end
    endcase
    // buffer occupancy: push and pop may coincide
    unique case ({SAMPLE_VALID && s_r.ready, done})
      2'b10: s_nxt.fill = s_r.fill + 2'd1;
      2'b01: begin
        s_nxt.fill = s_r.fill - 2'd1;
        s_nxt.buf0 = s_r.buf1;
      end
      2'b11: begin
        s_nxt.buf0 = (s_r.fill == 2'd1) ? SAMPLE_CODE : s_r.buf1;
        if (s_r.fill == 2'd2) begin
          s_nxt.buf1 = SAMPLE_CODE;
        end
      end
      default: s_nxt.fill = s_r.fill;
    endcase
    s_nxt.ready = (s_nxt.fill != 2'd2);
    // bus follows pins and next busy; oe rises on the same edge that loads the result and raises busy
    s_nxt.oe = s_r.rc_s && !s_r.cs_s && s_nxt.busy_n;
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      s_r <= '{cs_m: 1'b1, cs_s: 1'b1, rc_m: 1'b1, rc_s: 1'b1, st: SARP_TRACK,
               lowcnt: '0, convcnt: '0, result: SARP_CODE_ZERO, fill: 2'd0,
               buf0: SARP_CODE_ZERO, buf1: SARP_CODE_ZERO, busy_n: 1'b1, oe: 1'b0,
               ready: 1'b1, hold: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign LINK.busy_n = s_r.busy_n;
  assign LINK.result_bus_o = s_r.result;
  assign LINK.result_bus_oe = s_r.oe;
  assign SAMPLE_READY = s_r.ready;
  assign HOLD = s_r.hold;
endmodule

// ---- verilog/sarp_host.sv ----
// host end: issues convert pulses, reads result on busy rising
module sarp_host
  import sarp_pkg::*;
#(
  parameter int PULSE_CYC = SARP_PULSE_CYC,
  parameter int SETUP_CYC = SARP_SETUP_CYC,
  parameter int SPACING_CYC = SARP_SPACING_CYC
) (
  input wire logic MCLK,
  input wire logic RESETN,
  sarp_if.host LINK,
  input wire logic START,
  output logic DONE,
  output sarp_pkg::sarp_word_t RESULT,
  output logic IDLE
);
  import sarp_pkg::*;

  typedef enum logic [2:0] {SARH_IDLE, SARH_SETUP, SARH_PULSE, SARH_WAIT, SARH_GAP} sarh_state_t;
  typedef struct packed {
    logic busy_m;
    logic busy_s;
    logic busy_q;
    sarp_word_t d_m;
    sarp_word_t d_s;
    sarh_state_t st;
    logic [SARP_CNT_W-1:0] cnt;
    logic cs_n;
    logic rc;
    logic done;
    sarp_word_t result;
    logic idle;
  } sarp_host_st_t;

  sarp_host_st_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.busy_m = LINK.busy_n;
    s_nxt.busy_s = s_r.busy_m;
    s_nxt.busy_q = s_r.busy_s;
    s_nxt.d_m = LINK.result_bus_oe ? LINK.result_bus_o : SARP_CODE_ZERO;
    s_nxt.d_s = s_r.d_m;
    s_nxt.done = 1'b0;
    s_nxt.cnt = s_r.cnt + 1'b1;
    unique case (s_r.st)
      SARH_IDLE: begin
        s_nxt.cnt = '0;
        if (START) begin
          // cs leads so rc is the trigger
          s_nxt.cs_n = 1'b0;
          s_nxt.st = SARH_SETUP;
          s_nxt.idle = 1'b0;
        end
      end
      SARH_SETUP: begin
        if (s_r.cnt >= SARP_CNT_W'(SETUP_CYC - 1)) begin
          s_nxt.rc = 1'b0;
          s_nxt.st = SARH_PULSE;
          s_nxt.cnt = '0;
        end
      end
      SARH_PULSE: begin
        // extra margin covers the device's input synchroniser
        if (s_r.cnt >= SARP_CNT_W'(PULSE_CYC + 2)) begin
          s_nxt.rc = 1'b1; // rc high keeps read enabled for busy rising
          s_nxt.st = SARH_WAIT;
        end
      end
      SARH_WAIT: begin
        // bus stays untouched while converting
        if (s_r.busy_s && !s_r.busy_q) begin
          s_nxt.st = SARH_GAP;
          s_nxt.cnt = '0;
        end
      end
      SARH_GAP: begin
        if (s_r.cnt == SARP_CNT_W'(3)) begin
          s_nxt.result = s_r.d_s;
          s_nxt.done = 1'b1;
        end
        if (s_r.cnt >= SARP_CNT_W'(SPACING_CYC)) begin
          s_nxt.cs_n = 1'b1;
          s_nxt.st = SARH_IDLE;
          s_nxt.idle = 1'b1;
        end
      end
      default: s_nxt.st = SARH_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      s_r <= '{busy_m: 1'b1, busy_s: 1'b1, busy_q: 1'b1, d_m: SARP_CODE_ZERO,
               d_s: SARP_CODE_ZERO, st: SARH_IDLE, cnt: '0, cs_n: 1'b1, rc: 1'b1,
               done: 1'b0, result: SARP_CODE_ZERO, idle: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign LINK.cs_n = s_r.cs_n;
  assign LINK.rc = s_r.rc;
  assign DONE = s_r.done;
  assign RESULT = s_r.result;
  assign IDLE = s_r.idle;
endmodule

// ---- verilog/sarp_if.sv ----
// pin-level link between converter port and host
interface sarp_if;
  import sarp_pkg::*;
  logic cs_n;
  logic rc;
  logic busy_n;
  sarp_word_t result_bus_o;
  logic result_bus_oe;
  modport dev (input cs_n, input rc, output busy_n, output result_bus_o, output result_bus_oe);
  modport host (output cs_n, output rc, input busy_n, input result_bus_o, input result_bus_oe);
endinterface

// ---- verilog/sarp_pkg.sv ----
// shared constants and types for the converter parallel port
package sarp_pkg;
  localparam int SARP_DATA_W = 12;
  localparam int SARP_CLK_MHZ = 50;
  localparam int SARP_CLK_PS = 20000;
  localparam int SARP_CONV_PULSE_NS = 40;
  localparam int SARP_SETUP_NS = 10;
  localparam int SARP_SPACING_NS = 1660;
  localparam int SARP_CONV_TIME_NS = 1300;
  localparam int SARP_PULSE_CYC = (SARP_CONV_PULSE_NS * 1000 + SARP_CLK_PS - 1) / SARP_CLK_PS;
  localparam int SARP_SETUP_CYC = (SARP_SETUP_NS * 1000 + SARP_CLK_PS - 1) / SARP_CLK_PS;
  localparam int SARP_SPACING_CYC = (SARP_SPACING_NS * 1000 + SARP_CLK_PS - 1) / SARP_CLK_PS;
  localparam int SARP_CONV_CYC = (SARP_CONV_TIME_NS * 1000) / SARP_CLK_PS;
  localparam int SARP_CNT_W = 8;
  localparam logic [SARP_DATA_W-1:0] SARP_CODE_POS_FS = 12'h7FF;
  localparam logic [SARP_DATA_W-1:0] SARP_CODE_ZERO = 12'h000;
  localparam logic [SARP_DATA_W-1:0] SARP_CODE_NEG_LSB = 12'hFFF;
  localparam logic [SARP_DATA_W-1:0] SARP_CODE_NEG_FS = 12'h800;
  typedef logic [SARP_DATA_W-1:0] sarp_word_t;
endpackage
